// [core/p3d_port.sv]
/*
 Eight-bit pin port carrying the upper data byte in expanded modes
 and general-purpose I/O in single-chip modes, with its direction
 and output registers behind APB.
 Assumes pin inputs synchronous to clock_i, a bus controller that
 supplies write data and drive timing, and standby levels from the
 system controller.
*/
// Functional notes
// R1: The port is eight pins, data bus lines in modes 1 to 5 and general I/O in modes 6 and 7.
// R2: In expanded modes the pins carry bus traffic and the direction bits have no effect.
// R3: In single-chip modes a pin drives when its direction bit is 1 and is an input when 0.
// R4: The direction register is write-only and always reads back as all ones.
// R5: The direction register clears to zero on reset and hardware standby, and holds in software standby.
// R6: An output pin keeps driving its level during software standby.
// R7: A general-purpose output pin drives the matching output register bit.
// R8: A port read returns the output register bit where the direction bit is 1.
// R9: A port read returns the pin level where the direction bit is 0.
// R10: The output register is read/write, clears to zero on reset and hardware standby, and holds in software standby.
// R11: Port bit n connects to external data bus line n plus 8.
`timescale 1ns/1ns
`include "p3d_cfg.svh"

module p3d_port #(
   parameter int ADDR_W = 22,
   parameter int PORT_W = `P3D_PORT_W
) (
   // ----------------------------------------
   // Clock and reset
   // ----------------------------------------
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   // ----------------------------------------
   // APB
   // ----------------------------------------
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [ADDR_W-1:0]     paddr_i,
   input  wire logic [31:0]           pwdata_i,
   input  wire logic [3:0]            pstrb_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // ----------------------------------------
   // System mode and standby
   // ----------------------------------------
   input  wire logic [2:0]            op_mode_i,
   input  wire logic                  hw_standby_i,
   input  wire logic                  sw_standby_i,
   // ----------------------------------------
   // External data bus (from bus controller)
   // ----------------------------------------
   input  wire logic [`P3D_BUS_W-1:0] ext_bus_wdata_i,
   input  wire logic                  ext_bus_drive_i,
   output logic      [`P3D_BUS_W-1:0] ext_bus_rdata_o,
   // ----------------------------------------
   // Pads
   // ----------------------------------------
   input  wire logic [PORT_W-1:0]     pin_i,
   output logic      [PORT_W-1:0]     pin_o,
   output logic      [PORT_W-1:0]     pin_oe_o
);
   import p3d_pkg::*;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   generate
      if (PORT_W != `P3D_PORT_W) begin : g_bad_width
         $error("p3d_port: PORT_W must match the register width");
      end
      if (`P3D_BUS_LANE + PORT_W > `P3D_BUS_W) begin : g_bad_lane
         $error("p3d_port: port lane does not fit the data bus");
      end
   endgenerate

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   p3d_fn_e             fn;
   p3d_byte_t           dir_r;
   p3d_byte_t           dir_nxt;
   p3d_byte_t           out_r;
   p3d_byte_t           out_nxt;
   p3d_byte_t           port_read;
   p3d_byte_t           wdata;
   logic                wr_dir;
   logic                wr_out;
   logic [`P3D_BUS_W-1:0] brd_r;
   logic [`P3D_BUS_W-1:0] brd_nxt;

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   // Illegal code 0 parks the pins as inputs
   assign fn = p3d_decode_mode(op_mode_i);         // [R1]

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   p3d_apb_slave #(
      .ADDR_W (ADDR_W)
   ) u_apb (
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .psel_i      (psel_i),
      .penable_i   (penable_i),
      .pwrite_i    (pwrite_i),
      .paddr_i     (paddr_i),
      .pwdata_i    (pwdata_i),
      .pstrb_i     (pstrb_i),
      .prdata_o    (prdata_o),
      .pready_o    (pready_o),
      .pslverr_o   (pslverr_o),
      .port_read_i (port_read),
      .wr_dir_o    (wr_dir),
      .wr_out_o    (wr_out),
      .wdata_o     (wdata)
   );

   // ----------------------------------------
   // Direction and output registers
   // ----------------------------------------
   // Software standby simply leaves both registers alone
   always_comb begin
      dir_nxt = dir_r;
      out_nxt = out_r;
      if (hw_standby_i) begin
         dir_nxt = `P3D_RST_DIR;                   // [R5]
         out_nxt = `P3D_RST_OUT;                   // [R10]
      end else begin
         if (wr_dir) begin
            dir_nxt = wdata;                       // [R5]
         end
         if (wr_out) begin
            out_nxt = wdata;                       // [R10]
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         dir_r <= `P3D_RST_DIR;
         out_r <= `P3D_RST_OUT;
      end else begin
         dir_r <= dir_nxt;
         out_r <= out_nxt;
      end
   end

   // ----------------------------------------
   // Port read value
   // ----------------------------------------
   // Stored bit for outputs, live pin for inputs
   assign port_read = (dir_r & out_r) | (~dir_r & pin_i); // [R8] [R9]

   // ----------------------------------------
   // Bus read lane
   // ----------------------------------------
   // Lower byte belongs to another port and reads zero here
   always_comb begin
      brd_nxt = '0;
      for (int n = 0; n < PORT_W; n++) begin
         brd_nxt[n + `P3D_BUS_LANE] = pin_i[n];   // [R11]
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         brd_r <= '0;
      end else begin
         brd_r <= brd_nxt;
      end
   end

   assign ext_bus_rdata_o = brd_r;

   // ----------------------------------------
   // Pin cells
   // ----------------------------------------
   // sw_standby_i needs no gating: drive and registers persist
   for (genvar n = 0; n < PORT_W; n++) begin : g_pin
      p3d_pin_cell u_cell (
         .clock_i      (clock_i),
         .reset_i      (reset_i),
         .fn_i         (fn),
         .hw_standby_i (hw_standby_i),
         .dir_i        (dir_r[n]),
         .out_i        (out_r[n]),
         .bus_drive_i  (ext_bus_drive_i),
         .bus_bit_i    (ext_bus_wdata_i[n + `P3D_BUS_LANE]), // [R11]
         .pin_o        (pin_o[n]),
         .pin_oe_o     (pin_oe_o[n])
      );
   end

   // Only observed for completeness of the standby interface
   logic unused_sw_standby;
   assign unused_sw_standby = sw_standby_i;        // [R6]

endmodule : p3d_port

// [core/p3d_cfg.svh]
/*
 Offsets, reset values, mode codes and bus lane placement for the
 upper data byte port. Assumes inclusion by bare name from core files.
*/
`ifndef P3D_CFG_SVH
`define P3D_CFG_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define P3D_IDX_DIR      20'hee002
`define P3D_IDX_OUT      20'hfffd2
`define P3D_IDX_W        20

// ----------------------------------------
// Reset and read-back values
// ----------------------------------------
`define P3D_RST_DIR      8'h00
`define P3D_RST_OUT      8'h00
`define P3D_DIR_READ     8'hff
`define P3D_PORT_W       8

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define P3D_MODE_BUS_LO  3'h1
`define P3D_MODE_BUS_HI  3'h5
`define P3D_MODE_GPIO_LO 3'h6
`define P3D_MODE_GPIO_HI 3'h7

// ----------------------------------------
// External data bus placement
// ----------------------------------------
`define P3D_BUS_W        16
`define P3D_BUS_LANE     8

`endif

// [core/p3d_pkg.sv]
/*
 Types shared by the upper data byte port files.
 Assumes p3d_cfg.svh is reachable by bare name.
*/
`include "p3d_cfg.svh"

package p3d_pkg;

   // ----------------------------------------
   // Pin function selected by the mode pins
   // ----------------------------------------
   typedef enum logic [1:0] {
      P3D_FN_BUS,
      P3D_FN_GPIO,
      P3D_FN_OFF
   } p3d_fn_e;

   typedef logic [`P3D_PORT_W-1:0] p3d_byte_t;

   // ----------------------------------------
   // Mode code to pin function
   // ----------------------------------------
   function automatic p3d_fn_e p3d_decode_mode(input logic [2:0] mode);
      p3d_fn_e fn;
      fn = P3D_FN_OFF;
      if (mode >= `P3D_MODE_BUS_LO && mode <= `P3D_MODE_BUS_HI) begin
         fn = P3D_FN_BUS;
      end else if (mode >= `P3D_MODE_GPIO_LO && mode <= `P3D_MODE_GPIO_HI) begin
         fn = P3D_FN_GPIO;
      end
      return fn;
   endfunction : p3d_decode_mode

endpackage : p3d_pkg

// [core/p3d_apb_slave.sv]
/*
 APB slave front end for the port registers: decode, one wait
 state, registered answer. Assumes a single APB master and the
 clock and reset of the port.
*/
`timescale 1ns/1ns
`include "p3d_cfg.svh"

module p3d_apb_slave #(
   parameter int ADDR_W = 22
) (
   // ----------------------------------------
   // Clock and reset
   // ----------------------------------------
   input  wire logic              clock_i,
   input  wire logic              reset_i,
   // ----------------------------------------
   // APB
   // ----------------------------------------
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   input  wire logic [3:0]        pstrb_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // ----------------------------------------
   // Register side
   // ----------------------------------------
   input  wire p3d_pkg::p3d_byte_t port_read_i,
   output logic                   wr_dir_o,
   output logic                   wr_out_o,
   output p3d_pkg::p3d_byte_t     wdata_o
);
   import p3d_pkg::*;

   generate
      if (ADDR_W < `P3D_IDX_W + 2) begin : g_bad_addr
         $error("p3d_apb_slave: ADDR_W too small for register map");
      end
   endgenerate

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [`P3D_IDX_W-1:0] idx);
      return a == ADDR_W'({idx, 2'b00});
   endfunction : hit

   logic        ready_r;
   logic        ready_nxt;
   logic        err_r;
   logic        err_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        hit_dir;
   logic        hit_out;
   logic        commit;

   always_comb begin
      hit_dir   = hit(paddr_i, `P3D_IDX_DIR);
      hit_out   = hit(paddr_i, `P3D_IDX_OUT);
      // Answer one cycle into the access phase
      ready_nxt = psel_i & penable_i & ~ready_r;
      err_nxt   = ready_nxt & ~(hit_dir | hit_out);
      rdata_nxt = 32'h0;
      if (ready_nxt && !pwrite_i) begin
         if (hit_dir) begin
            rdata_nxt = {24'h0, `P3D_DIR_READ};    // [R4]
         end else if (hit_out) begin
            rdata_nxt = {24'h0, port_read_i};      // [R8] [R9]
         end
      end
      // Writes land on the edge where the master sees pready
      commit   = psel_i & penable_i & ready_r & pwrite_i & pstrb_i[0];
      wr_dir_o = commit & hit_dir;
      wr_out_o = commit & hit_out;                 // [R10]
      wdata_o  = pwdata_i[`P3D_PORT_W-1:0];
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ready_r <= 1'b0;
         err_r   <= 1'b0;
         rdata_r <= 32'h0;
      end else begin
         ready_r <= ready_nxt;
         err_r   <= err_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign pready_o  = ready_r;
   assign pslverr_o = err_r;
   assign prdata_o  = rdata_r;

endmodule : p3d_apb_slave

// [core/p3d_pin_cell.sv]
/*
 One port pin: selects bus or general-purpose drive and registers
 the pad output and its enable. Assumes the pad resolves the wire.
*/
`timescale 1ns/1ns

module p3d_pin_cell (
   // ----------------------------------------
   // Clock and reset
   // ----------------------------------------
   input  wire logic           clock_i,
   input  wire logic           reset_i,
   // ----------------------------------------
   // Control
   // ----------------------------------------
   input  wire p3d_pkg::p3d_fn_e fn_i,
   input  wire logic           hw_standby_i,
   input  wire logic           dir_i,
   input  wire logic           out_i,
   input  wire logic           bus_drive_i,
   input  wire logic           bus_bit_i,
   // ----------------------------------------
   // Pad
   // ----------------------------------------
   output logic                pin_o,
   output logic                pin_oe_o
);
   import p3d_pkg::*;

   logic pin_r;
   logic pin_nxt;
   logic oe_r;
   logic oe_nxt;

   always_comb begin
      pin_nxt = 1'b0;
      oe_nxt  = 1'b0;
      if (!hw_standby_i) begin
         unique case (fn_i)
            P3D_FN_BUS: begin
               // Direction bit ignored here
               oe_nxt  = bus_drive_i;              // [R2]
               pin_nxt = bus_bit_i;
            end
            P3D_FN_GPIO: begin
               // Software standby keeps this path live
               oe_nxt  = dir_i;                    // [R3] [R6]
               pin_nxt = out_i;                    // [R7]
            end
            P3D_FN_OFF: begin
               oe_nxt  = 1'b0;
               pin_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pin_r <= 1'b0;
         oe_r  <= 1'b0;
      end else begin
         pin_r <= pin_nxt;
         oe_r  <= oe_nxt;
      end
   end

   assign pin_o    = pin_r;
   assign pin_oe_o = oe_r;

endmodule : p3d_pin_cell

// [bench/p3d_port_asserts.sv]
/*
 Checker for the upper data byte port, bound to p3d_port.
 Assumes it sees only the top module ports.
*/
`timescale 1ns/1ns
`include "p3d_cfg.svh"

module p3d_port_asserts #(
   parameter int ADDR_W = 22,
   parameter int PORT_W = `P3D_PORT_W
) (
   // Clock and reset
   input wire logic                  clock_i,
   input wire logic                  reset_i,
   // APB
   input wire logic                  psel_i,
   input wire logic                  penable_i,
   input wire logic                  pwrite_i,
   input wire logic [ADDR_W-1:0]     paddr_i,
   input wire logic [31:0]           prdata_o,
   input wire logic                  pready_o,
   input wire logic                  pslverr_o,
   // Mode, standby and pins
   input wire logic [2:0]            op_mode_i,
   input wire logic                  hw_standby_i,
   input wire logic                  sw_standby_i,
   input wire logic [`P3D_BUS_W-1:0] ext_bus_wdata_i,
   input wire logic                  ext_bus_drive_i,
   input wire logic [`P3D_BUS_W-1:0] ext_bus_rdata_o,
   input wire logic [PORT_W-1:0]     pin_i,
   input wire logic [PORT_W-1:0]     pin_o,
   input wire logic [PORT_W-1:0]     pin_oe_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   logic hit_dir;
   logic hit_out;
   logic bus_m;
   logic gpio_m;
   assign hit_dir = (paddr_i == ADDR_W'({`P3D_IDX_DIR, 2'h0}));
   assign hit_out = (paddr_i == ADDR_W'({`P3D_IDX_OUT, 2'h0}));
   assign bus_m   = (op_mode_i >= `P3D_MODE_BUS_LO) && (op_mode_i <= `P3D_MODE_BUS_HI);
   assign gpio_m  = (op_mode_i >= `P3D_MODE_GPIO_LO);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_dir_reads_ones: assert property (psel_i && !pwrite_i && hit_dir && pready_o |-> prdata_o == 32'h000000ff)
      else $error("direction read not all ones");
   chk_hw_standby_clear: assert property (hw_standby_i |=> pin_oe_o == '0)
      else $error("pins still driven in hardware standby");
   chk_bus_drive_all: assert property (bus_m && ext_bus_drive_i && !hw_standby_i |=> pin_oe_o == '1)
      else $error("bus drive not on all pins");
   chk_bus_release: assert property (bus_m && !ext_bus_drive_i && !hw_standby_i |=> pin_oe_o == '0)
      else $error("bus pins driven while released");
   chk_bus_lane_out: assert property (bus_m && ext_bus_drive_i && !hw_standby_i
      |=> pin_o == $past(ext_bus_wdata_i[15:8]))
      else $error("bus write byte on wrong lane");
   chk_bus_lane_in: assert property (1'b1 |=> ext_bus_rdata_o == {$past(pin_i), 8'h00})
      else $error("bus read byte on wrong lane");
   chk_gpio_hold: assert property (gpio_m && $stable(op_mode_i) && !psel_i && !$past(psel_i)
      && !hw_standby_i && !$past(hw_standby_i) |=> $stable(pin_oe_o) && $stable(pin_o))
      else $error("output pins changed with no write");
   chk_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
      else $error("answer not one cycle after access");
   chk_apb_decode: assert property (pready_o |-> pslverr_o == !(hit_dir || hit_out))
      else $error("error response wrong for address");

   cov_sw_standby: cover property (sw_standby_i && gpio_m && pin_oe_o != '0);
   cov_bus_drive: cover property (bus_m && ext_bus_drive_i ##1 pin_oe_o == '1);
   cov_dir_read: cover property (pready_o && hit_dir && !pwrite_i);
   cov_unmapped: cover property (pready_o && pslverr_o);
endmodule : p3d_port_asserts

bind p3d_port p3d_port_asserts #(.ADDR_W(ADDR_W), .PORT_W(PORT_W)) i_p3d_port_asserts (
   .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .op_mode_i(op_mode_i), .hw_standby_i(hw_standby_i),
   .sw_standby_i(sw_standby_i), .ext_bus_wdata_i(ext_bus_wdata_i), .ext_bus_drive_i(ext_bus_drive_i),
   .ext_bus_rdata_o(ext_bus_rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));

// [bench/p3d_bus_peer.sv]
/*
 Far side of the port pins: memory or peripheral on the data bus.
 Assumes the port drives pin_o where pin_oe_o is high.
*/
`timescale 1ns/1ns

module p3d_bus_peer (
   // Clock
   input  wire logic       clock_i,
   // Port pads
   input  wire logic [7:0] pin_o,
   input  wire logic [7:0] pin_oe_o,
   // Bench control
   input  wire logic       peer_drive_i,
   input  wire logic [7:0] peer_val_i,
   // Resolved wire
   output logic      [7:0] pin_i
);
   logic [7:0] last_r;
   // No pull-ups: a floating line shows the inverse of its last level
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         pin_i[b] = pin_oe_o[b] ? pin_o[b] : (peer_drive_i ? peer_val_i[b] : ~last_r[b]);
      end
   end
   always_ff @(posedge clock_i) begin
      last_r <= pin_i;
   end
endmodule : p3d_bus_peer

// [bench/test_port3_io_data_bus.sv]
/*
 Testbench for the upper data byte port: APB tasks, mode and
 standby sequences. Assumes the design and checker files compiled.
*/
`timescale 1ns/1ns
`include "p3d_cfg.svh"

module test_port3_io_data_bus;
   localparam logic [21:0] A_DIR = {`P3D_IDX_DIR, 2'h0};
   localparam logic [21:0] A_OUT = {`P3D_IDX_OUT, 2'h0};

   logic clock_i, reset_i, psel_i, penable_i, pwrite_i;
   logic [21:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic pready_o, pslverr_o, hw_standby_i, sw_standby_i, ext_bus_drive_i, err, peer_drive;
   logic [2:0] op_mode_i;
   logic [15:0] ext_bus_wdata_i, ext_bus_rdata_o;
   logic [7:0] pin_i, pin_o, pin_oe_o, peer_val, b;
   int bad_count, tests_run;

   p3d_port i_p3d_port (
      .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .op_mode_i(op_mode_i),
      .hw_standby_i(hw_standby_i), .sw_standby_i(sw_standby_i), .ext_bus_wdata_i(ext_bus_wdata_i),
      .ext_bus_drive_i(ext_bus_drive_i), .ext_bus_rdata_o(ext_bus_rdata_o), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o));
   p3d_bus_peer i_p3d_bus_peer (.clock_i(clock_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
      .peer_drive_i(peer_drive), .peer_val_i(peer_val), .pin_i(pin_i));

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Waits for pready at each edge; the watchdog ends a hang
   task automatic apb(input logic wr, input logic [21:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask : apb

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask : cyc

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // Whole run is well under a thousand cycles
   initial begin
      #40000;
      bad_count++;
      finish_test;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel_i, penable_i, pwrite_i, hw_standby_i, sw_standby_i, ext_bus_drive_i} = '0;
      paddr_i = '0;
      pwdata_i = '0;
      ext_bus_wdata_i = '0;
      op_mode_i = 3'h6;
      peer_drive = 1'b1;
      peer_val = 8'h5a;
      bad_count = 0;
      tests_run = 0;
      reset_i = 1'b1;
      repeat (12) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      apb(1'b0, A_DIR, 32'h0); chk(rd, 32'h000000ff);
      apb(1'b0, A_OUT, 32'h0); chk(rd, 32'h0000005a);
      chk(pin_oe_o, 8'h00);
      apb(1'b1, A_DIR, 32'hf0);
      apb(1'b1, A_OUT, 32'ha5);
      cyc(2);
      chk(pin_oe_o, 8'hf0);
      chk(pin_o & 8'hf0, 8'ha0);
      apb(1'b0, A_OUT, 32'h0); chk(rd, 32'h000000aa);
      apb(1'b0, A_DIR, 32'h0); chk(rd, 32'h000000ff);
      // Software standby keeps registers and drive
      sw_standby_i <= 1'b1;
      cyc(5);
      chk(pin_oe_o, 8'hf0);
      chk(pin_o & 8'hf0, 8'ha0);
      apb(1'b0, A_OUT, 32'h0); chk(rd, 32'h000000aa);
      sw_standby_i <= 1'b0;
      // Every expanded mode: bus owns the pins, direction ignored
      for (int m = 1; m <= 5; m++) begin
         b = 8'h3c ^ 8'(m);
         op_mode_i <= 3'(m);
         ext_bus_drive_i <= 1'b1;
         ext_bus_wdata_i <= {b, 8'h00};
         cyc(2);
         chk(pin_oe_o, 8'hff);
         chk(pin_o, b);
         ext_bus_drive_i <= 1'b0;
         peer_val <= ~b;
         cyc(3);
         chk(pin_oe_o, 8'h00);
         chk(ext_bus_rdata_o, {~b, 8'h00});
      end
      // Hardware standby clears both registers
      op_mode_i <= 3'h6;
      hw_standby_i <= 1'b1;
      cyc(2);
      hw_standby_i <= 1'b0;
      cyc(2);
      chk(pin_oe_o, 8'h00);
      apb(1'b1, A_DIR, 32'hff);
      cyc(2);
      chk(pin_o, 8'h00);
      apb(1'b0, A_OUT, 32'h0); chk(rd, 32'h00000000);
      // Mid-run reset clears both registers again
      apb(1'b1, A_OUT, 32'h3c);
      reset_i <= 1'b1;
      cyc(2);
      reset_i <= 1'b0;
      cyc(2);
      chk(pin_oe_o, 8'h00);
      apb(1'b1, A_DIR, 32'hff);
      apb(1'b0, A_OUT, 32'h0); chk(rd, 32'h00000000);
      apb(1'b0, 22'h000004, 32'h0); chk({31'h0, err}, 32'h1);
      finish_test;
   end
endmodule : test_port3_io_data_bus
